// ---- rtl/engine_run_state_qualifier.sv ----
// engine run-state qualifier and generator tolerance timing
// assumes synchronous measurement inputs on core_clk_in; pins pass 2-flop sync
//
// Functional notes
// R1 - generator steady out of tolerance after two seconds continuously not in tolerance
// R2 - steady out: lamp off if voltage and frequency absent, else blinking
// R3 - steady in tolerance after 0.5 s of both in tolerance; lamp steadily on
// R4 - lamp blinks while moving between the two steady states
// R5 - with event mask bit 2, each status change logs one of three events
// R6 - in-threshold output after tolerance held for configured qualification time
// R7 - stopped allows starter; running drops starter and blocks restart
// R8 - in movement keeps active starter, blocks a new start
// R9 - two-threshold check needs both thresholds nonzero and upper above lower
// R10 - speed check enabled by speed measurement or CAN link; three speed bands
// R11 - D+ check only with D+ analogue input assigned; three bands
// R12 - oil check needs delay and sensors; moving after pressure held for delay
// R13 - voltage check: all phases low stopped, any above upper running
// R14 - frequency check: stopped below lower, moving between, running above upper
// R15 - CAN check reports running on started; ignored when engine type is 0
// R16 - combined stopped after all enabled checks stopped for five seconds
// R17 - combined moving when any enabled check moves or runs and running is not yet qualified
// R18 - combined running after any check running for 0.2 seconds
// R19 - timers advance on periodic tick; reset clears timers, sets engine to stopped, generator to steady out
`timescale 1ns/1ns
`default_nettype none
module engine_run_state_qualifier (
   input  wire logic                       core_clk_in,                // system clock
   input  wire logic                       rst_in,                     // async reset, high
   input  wire run_state_pkg::meas_t       meas_in,                    // measurements
   input  wire run_state_pkg::cfg_t        cfg_in,                     // parameters
   input  wire run_state_pkg::gen_status_t gen_status_in,              // tolerance bands
   input  wire logic                       start_request_in,           // starter demanded
   output var  run_state_pkg::eng_state_t  engine_state_out,           // combined state
   output var  logic                       starter_cmd_out,            // starter command
   output var  run_state_pkg::gen_state_t  gen_state_out,              // generator state
   output var  logic                       gen_present_lamp_out,       // live lamp
   output var  logic                       gen_in_threshold_output_out,// in thresholds
   output var  logic                       evt_gen_voltage_lacking_out,  // event pulse
   output var  logic                       evt_gen_out_of_tolerance_out, // event pulse
   output var  logic                       evt_gen_within_tolerance_out  // event pulse
);
   import run_state_pkg::*;

   // =====================================================
   // state record
   typedef struct packed {
      // pin synchroniser and evaluation tick counter
      logic [1:0]        sw_sync1;
      logic [1:0]        sw_sync2;
      logic [TICK_W-1:0] tick_cnt;
      logic              tick;
      // qualification timers and lamp blink phase
      logic [TMR_W-1:0]  oil_tmr;
      logic [TMR_W-1:0]  stop_tmr;
      logic [TMR_W-1:0]  run_tmr;
      logic [TMR_W-1:0]  out_tmr;
      logic [TMR_W-1:0]  in_tmr;
      logic [TMR_W-1:0]  thr_tmr;
      logic [TMR_W-1:0]  blink_tmr;
      logic              blink;
      // outputs and last event code
      eng_state_t        eng;
      logic              starter;
      gen_state_t        gen;
      logic              lamp;
      logic              in_thr;
      logic [1:0]        last_evt;
      logic              evt_lack;
      logic              evt_out;
      logic              evt_in;
   } state_t;

   state_t st;
   state_t next_st;

   // =====================================================
   // helpers
   function automatic logic [TMR_W-1:0] sat_inc(input logic [TMR_W-1:0] v);
      sat_inc = (v == {TMR_W{1'b1}}) ? v : v + 16'h0001;
   endfunction : sat_inc

   function automatic logic is_moving_or_run(input eng_state_t s);
      is_moving_or_run = (s != ENG_STOPPED);
   endfunction : is_moving_or_run

   // =====================================================
   // instantaneous checks
   logic       spd_en;
   logic       dp_en;
   logic       v_en;
   logic       f_en;
   eng_state_t spd_s;
   eng_state_t dp_s;
   eng_state_t f_s;
   eng_state_t v_s;
   eng_state_t v1_s;
   eng_state_t v2_s;
   eng_state_t v3_s;
   logic       spd_avail;
   logic       can_en;

   assign can_en    = (cfg_in.engine_type != ENGINE_TYPE_NONE); // R15
   assign spd_avail = (cfg_in.pickup_teeth != 8'h00) || (cfg_in.rpm_per_volt != 16'h0000) ||
                      (cfg_in.rpm_per_hz != 16'h0000) || can_en; // R10

   two_thr_check u_speed (
      .value_in    (meas_in.speed),
      .lo_in       (cfg_in.speed_lo),
      .hi_in       (cfg_in.speed_hi),
      .avail_in    (spd_avail),
      .enabled_out (spd_en),
      .state_out   (spd_s)
   );

   two_thr_check u_dplus (
      .value_in    (meas_in.dplus),
      .lo_in       (cfg_in.dplus_lo),
      .hi_in       (cfg_in.dplus_hi),
      .avail_in    (cfg_in.charger_dplus_input_function), // R11
      .enabled_out (dp_en),
      .state_out   (dp_s)
   );

   two_thr_check u_freq (
      .value_in    (meas_in.freq),
      .lo_in       (cfg_in.freq_lo),
      .hi_in       (cfg_in.freq_hi),
      .avail_in    (1'b1),
      .enabled_out (f_en),
      .state_out   (f_s) // R14
   );

   two_thr_check u_volt1 (
      .value_in    (meas_in.volt_l1),
      .lo_in       (cfg_in.volt_lo),
      .hi_in       (cfg_in.volt_hi),
      .avail_in    (1'b1),
      .enabled_out (v_en),
      .state_out   (v1_s)
   );

   two_thr_check u_volt2 (
      .value_in    (meas_in.volt_l2),
      .lo_in       (cfg_in.volt_lo),
      .hi_in       (cfg_in.volt_hi),
      .avail_in    (1'b1),
      .enabled_out (),
      .state_out   (v2_s)
   );

   two_thr_check u_volt3 (
      .value_in    (meas_in.volt_l3),
      .lo_in       (cfg_in.volt_lo),
      .hi_in       (cfg_in.volt_hi),
      .avail_in    (1'b1),
      .enabled_out (),
      .state_out   (v3_s)
   );

   // any phase above upper runs, any above lower moves
   always_comb begin
      if (v1_s == ENG_RUNNING || v2_s == ENG_RUNNING || v3_s == ENG_RUNNING) begin
         v_s = ENG_RUNNING; // R13
      end else if (is_moving_or_run(v1_s) || is_moving_or_run(v2_s) || is_moving_or_run(v3_s)) begin
         v_s = ENG_MOVING; // R13
      end else begin
         v_s = ENG_STOPPED; // R13
      end
   end

   // =====================================================
   // next state
   logic       oil_en;
   logic       oil_low;
   logic       any_run;
   logic       any_move;
   logic       all_stop;
   logic       gen_all_in;
   logic       gen_absent;
   logic       gen_changed;
   logic [1:0] evt_code;
   logic       stop_qual;
   logic       run_qual;
   logic       in_qual;
   logic       out_qual;

   always_comb begin
      next_st = st;
      next_st.sw_sync1 = {meas_in.oil_low_pressure_switch, meas_in.oil_min_pressure_switch};
      next_st.sw_sync2 = st.sw_sync1;

      // one-cycle event pulses
      next_st.evt_lack = 1'b0;
      next_st.evt_out  = 1'b0;
      next_st.evt_in   = 1'b0;

      // periodic evaluation tick
      if (st.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
         next_st.tick_cnt = '0; // R19
         next_st.tick     = 1'b1;
      end else begin
         next_st.tick_cnt = st.tick_cnt + 18'h00001;
         next_st.tick     = 1'b0;
      end

      // oil: switches active means pressure low
      oil_en  = (cfg_in.oil_delay_ticks != 16'h0000) &&
                (cfg_in.oil_switches_fitted || cfg_in.oil_meas_available); // R12
      oil_low = (cfg_in.oil_switches_fitted && (st.sw_sync2 != 2'b00)) ||
                (cfg_in.oil_meas_available && meas_in.oil_below_min);

      any_run = (spd_en && spd_s == ENG_RUNNING) || (dp_en && dp_s == ENG_RUNNING) ||
                (v_en && v_s == ENG_RUNNING) || (f_en && f_s == ENG_RUNNING) ||
                (can_en && meas_in.can_started); // R15
      any_move = any_run || (spd_en && spd_s == ENG_MOVING) || (dp_en && dp_s == ENG_MOVING) ||
                 (v_en && v_s == ENG_MOVING) || (f_en && f_s == ENG_MOVING) ||
                 (oil_en && !oil_low && st.oil_tmr >= cfg_in.oil_delay_ticks); // R12 R17
      all_stop = !any_move && !(oil_en && !oil_low);

      gen_all_in = (gen_status_in.volt_global == GEN_IN_TOL) && (gen_status_in.freq == GEN_IN_TOL);
      gen_absent = (gen_status_in.volt_global == GEN_ABSENT) && (gen_status_in.freq == GEN_ABSENT);

      // timers clear on ticks only; gate with live cause
      stop_qual = all_stop && st.stop_tmr >= TMR_W'(STOP_QUAL_TICKS);
      run_qual  = any_run && st.run_tmr >= TMR_W'(RUN_QUAL_TICKS);
      in_qual   = gen_all_in && st.in_tmr >= TMR_W'(IN_TOL_TICKS);
      out_qual  = !gen_all_in && st.out_tmr >= TMR_W'(OUT_TOL_TICKS);

      if (st.tick) begin
         next_st.oil_tmr   = (oil_en && !oil_low) ? sat_inc(st.oil_tmr) : '0; // R12
         next_st.stop_tmr  = all_stop ? sat_inc(st.stop_tmr) : '0; // R16
         next_st.run_tmr   = any_run ? sat_inc(st.run_tmr) : '0; // R18
         next_st.out_tmr   = gen_all_in ? '0 : sat_inc(st.out_tmr); // R1
         next_st.in_tmr    = gen_all_in ? sat_inc(st.in_tmr) : '0; // R3
         next_st.thr_tmr   = gen_all_in ? sat_inc(st.thr_tmr) : '0; // R6

         // lamp blink phase
         if (st.blink_tmr >= TMR_W'(BLINK_TICKS - 1)) begin
            next_st.blink_tmr = '0;
            next_st.blink     = !st.blink;
         end else begin
            next_st.blink_tmr = st.blink_tmr + 16'h0001;
         end
      end

      // combined engine state
      if (stop_qual) begin
         next_st.eng = ENG_STOPPED; // R16
      end else if (run_qual) begin
         next_st.eng = ENG_RUNNING; // R18
      end else if (any_move) begin
         next_st.eng = ENG_MOVING; // R17
      end else begin
         next_st.eng = st.eng;
      end

      // starter gating
      case (st.eng)
         ENG_STOPPED: next_st.starter = start_request_in; // R7
         ENG_MOVING:  next_st.starter = st.starter && start_request_in; // R8
         ENG_RUNNING: next_st.starter = 1'b0; // R7
         default:     next_st.starter = 1'b0;
      endcase

      // generator tolerance state
      case (st.gen)
         GS_OUT_STEADY: begin
            if (gen_all_in) begin
               next_st.gen = GS_TRANSIENT; // R4
            end
         end

         GS_TRANSIENT: begin
            if (in_qual) begin
               next_st.gen = GS_IN_STEADY; // R3
            end else if (out_qual) begin
               next_st.gen = GS_OUT_STEADY; // R1
            end
         end

         GS_IN_STEADY: begin
            if (!gen_all_in) begin
               next_st.gen = GS_TRANSIENT; // R4
            end
         end

         default: begin
            next_st.gen = GS_OUT_STEADY;
         end
      endcase

      // lamp lags the state by one cycle
      case (st.gen)
         GS_IN_STEADY:  next_st.lamp = 1'b1; // R3
         GS_OUT_STEADY: next_st.lamp = gen_absent ? 1'b0 : st.blink; // R2
         default:       next_st.lamp = st.blink; // R4
      endcase

      // no delay set: immediate
      next_st.in_thr = (cfg_in.in_thr_delay_ticks == 16'h0000) ? gen_all_in :
                       (gen_all_in && st.thr_tmr >= cfg_in.in_thr_delay_ticks); // R6

      // status change events
      // codes: 1 lacking, 2 out, 3 within
      if (gen_absent) begin
         evt_code = 2'h1;
      end else if (st.gen == GS_IN_STEADY) begin
         evt_code = 2'h3;
      end else if (st.gen == GS_OUT_STEADY) begin
         evt_code = 2'h2;
      end else begin
         evt_code = st.last_evt;
      end
      gen_changed = (evt_code != st.last_evt);
      next_st.last_evt = evt_code;

      if (gen_changed && cfg_in.event_enable_mask[EVT_EN_BIT]) begin
         next_st.evt_lack = (evt_code == 2'h1); // R5
         next_st.evt_out  = (evt_code == 2'h2); // R5
         next_st.evt_in   = (evt_code == 2'h3); // R5
      end
   end

   // =====================================================
   // registers
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         st <= '{eng: ENG_STOPPED, gen: GS_OUT_STEADY, default: '0}; // R19
      end else begin
         st <= next_st;
      end
   end

   assign engine_state_out             = st.eng;
   assign starter_cmd_out              = st.starter;
   assign gen_state_out                = st.gen;
   assign gen_present_lamp_out         = st.lamp;
   assign gen_in_threshold_output_out  = st.in_thr;
   assign evt_gen_voltage_lacking_out  = st.evt_lack;
   assign evt_gen_out_of_tolerance_out = st.evt_out;
   assign evt_gen_within_tolerance_out = st.evt_in;

endmodule : engine_run_state_qualifier
`default_nettype wire

// ---- rtl/run_state_pkg.sv ----
// package: types, constants and timing counts for the engine run-state qualifier
// assumes a 20 MHz core clock and a 10 ms evaluation tick
package run_state_pkg;

   // =====================================================
   // timing
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned TICK_MS         = 10;
   localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned OUT_TOL_MS      = 2000;
   localparam int unsigned IN_TOL_MS       = 500;
   localparam int unsigned STOP_QUAL_MS    = 5000;
   localparam int unsigned RUN_QUAL_MS     = 200;
   localparam int unsigned BLINK_MS        = 500;
   localparam int unsigned OUT_TOL_TICKS   = OUT_TOL_MS / TICK_MS;
   localparam int unsigned IN_TOL_TICKS    = (IN_TOL_MS + TICK_MS - 1) / TICK_MS;
   localparam int unsigned STOP_QUAL_TICKS = STOP_QUAL_MS / TICK_MS;
   localparam int unsigned RUN_QUAL_TICKS  = (RUN_QUAL_MS + TICK_MS - 1) / TICK_MS;
   localparam int unsigned BLINK_TICKS     = BLINK_MS / TICK_MS;

   localparam int unsigned TICK_W  = 18;
   localparam int unsigned TMR_W   = 16;
   localparam int unsigned MEAS_W  = 16;
   localparam int unsigned EVT_EN_BIT = 2;
   localparam logic [7:0] ENGINE_TYPE_NONE = 8'h00;

   // =====================================================
   // types
   typedef enum logic [1:0] {
      ENG_STOPPED,
      ENG_MOVING,
      ENG_RUNNING
   } eng_state_t;

   typedef enum logic [1:0] {
      GEN_ABSENT,
      GEN_LOW,
      GEN_IN_TOL,
      GEN_HIGH
   } band_t;

   typedef enum logic [1:0] {
      GS_OUT_STEADY,
      GS_TRANSIENT,
      GS_IN_STEADY
   } gen_state_t;

   // measurements
   typedef struct packed {
      logic [MEAS_W-1:0] speed;
      logic [MEAS_W-1:0] dplus;
      logic [MEAS_W-1:0] volt_l1;
      logic [MEAS_W-1:0] volt_l2;
      logic [MEAS_W-1:0] volt_l3;
      logic [MEAS_W-1:0] freq;
      logic              oil_low_pressure_switch;
      logic              oil_min_pressure_switch;
      logic              oil_below_min;
      logic              can_started;
   } meas_t;

   // configuration
   typedef struct packed {
      logic [MEAS_W-1:0] speed_lo;
      logic [MEAS_W-1:0] speed_hi;
      logic [MEAS_W-1:0] dplus_lo;
      logic [MEAS_W-1:0] dplus_hi;
      logic [MEAS_W-1:0] volt_lo;
      logic [MEAS_W-1:0] volt_hi;
      logic [MEAS_W-1:0] freq_lo;
      logic [MEAS_W-1:0] freq_hi;
      logic [7:0]        pickup_teeth;
      logic [MEAS_W-1:0] rpm_per_volt;
      logic [MEAS_W-1:0] rpm_per_hz;
      logic [7:0]        engine_type;
      logic              charger_dplus_input_function;
      logic              oil_switches_fitted;
      logic              oil_meas_available;
      logic [TMR_W-1:0]  oil_delay_ticks;
      logic [TMR_W-1:0]  in_thr_delay_ticks;
      logic [7:0]        event_enable_mask;
   } cfg_t;

   // generator tolerance status
   typedef struct packed {
      band_t volt_global;
      band_t freq;
   } gen_status_t;

endpackage : run_state_pkg

// ---- rtl/two_thr_check.sv ----
// two-threshold classifier: stopped / moving / running with validity
// assumes inputs from the same clock domain
`timescale 1ns/1ns
`default_nettype none
module two_thr_check (
   input  wire logic [15:0]               value_in,   // measurement
   input  wire logic [15:0]               lo_in,      // lower threshold
   input  wire logic [15:0]               hi_in,      // upper threshold
   input  wire logic                      avail_in,   // measurement exists
   output var  logic                      enabled_out,// check in use
   output var  run_state_pkg::eng_state_t state_out   // instant state
);
   import run_state_pkg::*;

   always_comb begin
      enabled_out = avail_in && (lo_in != 16'h0000) && (hi_in != 16'h0000) && (hi_in > lo_in); // R9
      if (value_in > hi_in) begin
         state_out = ENG_RUNNING;
      end else if (value_in > lo_in) begin
         state_out = ENG_MOVING;
      end else begin
         state_out = ENG_STOPPED;
      end
   end
endmodule : two_thr_check
`default_nettype wire

// ---- test/engine_run_state_qualifier_asserts.sv ----
// checker: temporal properties on the run-state qualifier ports
// assumes it is bound into engine_run_state_qualifier, one clock domain
`timescale 1ns/1ns
`default_nettype none
module engine_run_state_qualifier_chk (
   input wire logic                       core_clk_in,                  // clock
   input wire logic                       rst_in,                       // reset
   input wire run_state_pkg::cfg_t        cfg_in,                       // parameters
   input wire run_state_pkg::gen_status_t gen_status_in,                // bands
   input wire logic                       start_request_in,             // demand
   input wire run_state_pkg::eng_state_t  engine_state_out,             // state
   input wire logic                       starter_cmd_out,              // starter
   input wire run_state_pkg::gen_state_t  gen_state_out,                // gen state
   input wire logic                       gen_present_lamp_out,         // lamp
   input wire logic                       gen_in_threshold_output_out,  // in thr
   input wire logic                       evt_gen_voltage_lacking_out,  // event
   input wire logic                       evt_gen_out_of_tolerance_out, // event
   input wire logic                       evt_gen_within_tolerance_out  // event
);
   import run_state_pkg::*;
   wire logic [2:0] evts = {evt_gen_voltage_lacking_out, evt_gen_out_of_tolerance_out, evt_gen_within_tolerance_out};
   wire logic all_in = gen_status_in.volt_global == GEN_IN_TOL && gen_status_in.freq == GEN_IN_TOL;
   wire logic all_abs = gen_status_in.volt_global == GEN_ABSENT && gen_status_in.freq == GEN_ABSENT;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   // =====================================================
   // engine and starter
   chk_reset_vals: assert property ($fell(rst_in) |-> engine_state_out == ENG_STOPPED
      && gen_state_out == GS_OUT_STEADY && !starter_cmd_out) else $error("outputs not cleared by reset");
   chk_stop_pass: assert property (engine_state_out == ENG_STOPPED |=>
      starter_cmd_out == $past(start_request_in)) else $error("starter not following request");
   chk_run_block: assert property (engine_state_out == ENG_RUNNING |=> !starter_cmd_out)
      else $error("starter active while running");
   chk_move_hold: assert property (engine_state_out == ENG_MOVING |=>
      starter_cmd_out == ($past(starter_cmd_out) && $past(start_request_in))) else $error("starter wrong while moving");
   // =====================================================
   // generator status
   chk_enter_trans: assert property (gen_state_out == GS_OUT_STEADY && all_in |->
      ##[1:2] gen_state_out == GS_TRANSIENT) else $error("no transient after tolerance reached");
   chk_leave_steady: assert property (gen_state_out == GS_IN_STEADY && !all_in |=>
      gen_state_out == GS_TRANSIENT) else $error("steady in kept after tolerance lost");
   chk_lamp_on: assert property ((gen_state_out == GS_IN_STEADY) [*2] |-> gen_present_lamp_out)
      else $error("lamp not on in steady tolerance");
   chk_lamp_off: assert property ((gen_state_out == GS_OUT_STEADY && all_abs) [*2] |->
      !gen_present_lamp_out) else $error("lamp lit with generator absent");
   chk_thr_cause: assert property (gen_in_threshold_output_out |-> $past(all_in))
      else $error("in-threshold output without tolerance");
   chk_evt_mask: assert property (!$past(cfg_in.event_enable_mask[2]) |-> evts == 3'h0)
      else $error("event while events disabled");
   chk_evt_single: assert property ($onehot0(evts))
      else $error("two events in one cycle");
   cov_moving: cover property (engine_state_out == ENG_MOVING);
   cov_trans: cover property (gen_state_out == GS_TRANSIENT);
   cov_lack: cover property (evt_gen_voltage_lacking_out);
   cov_thr: cover property (gen_in_threshold_output_out);
endmodule : engine_run_state_qualifier_chk
bind engine_run_state_qualifier engine_run_state_qualifier_chk i_engine_run_state_qualifier_chk (
   .core_clk_in(core_clk_in), .rst_in(rst_in), .cfg_in(cfg_in), .gen_status_in(gen_status_in),
   .start_request_in(start_request_in), .engine_state_out(engine_state_out), .starter_cmd_out(starter_cmd_out),
   .gen_state_out(gen_state_out), .gen_present_lamp_out(gen_present_lamp_out),
   .gen_in_threshold_output_out(gen_in_threshold_output_out),
   .evt_gen_voltage_lacking_out(evt_gen_voltage_lacking_out),
   .evt_gen_out_of_tolerance_out(evt_gen_out_of_tolerance_out),
   .evt_gen_within_tolerance_out(evt_gen_within_tolerance_out));
`default_nettype wire

// ---- test/engine_sensor_model.sv ----
// partner: engine sensors and engine unit as seen by the qualifier
// assumes the bench sets the wanted engine condition on cmd_in
`timescale 1ns/1ns
`default_nettype none
module engine_sensor_model (
   input  wire run_state_pkg::meas_t cmd_in,      // wanted condition
   input  wire logic                 core_clk_in, // clock
   output var  run_state_pkg::meas_t meas_out     // sensed values
);
   import run_state_pkg::*;
   initial meas_out = '0;
   // sensors sample once a cycle; contacts report low pressure below minimum
   always @(posedge core_clk_in) begin
      meas_out <= cmd_in;
      meas_out.oil_low_pressure_switch <= cmd_in.oil_below_min;
      meas_out.oil_min_pressure_switch <= cmd_in.oil_below_min;
   end
endmodule : engine_sensor_model
`default_nettype wire

// ---- test/tb_engine_run_state_qualifier.sv ----
// bench: self-checking run of the run-state qualifier against a reference model
// assumes the rtl package, design modules, checker and sensor model compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_engine_run_state_qualifier;
   import run_state_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        req = 1'b0;
   cfg_t        cfg = '0;
   meas_t       cmd = '0;
   meas_t       meas;
   gen_status_t gst = '0;
   eng_state_t  eng;
   gen_state_t  gs;
   logic        strt, lamp, thr, e_lack, e_out, e_in;
   int          bad_count = 0;
   int          n_compared = 0;
   int          n_lack, n_out, n_in;
   logic [15:0] lfsr = 16'hA785;
   always #25 clk = ~clk;
   engine_sensor_model i_engine_sensor_model (.core_clk_in(clk), .cmd_in(cmd), .meas_out(meas));
   engine_run_state_qualifier i_engine_run_state_qualifier (.core_clk_in(clk), .rst_in(rst), .meas_in(meas),
      .cfg_in(cfg), .gen_status_in(gst), .start_request_in(req), .engine_state_out(eng), .starter_cmd_out(strt),
      .gen_state_out(gs), .gen_present_lamp_out(lamp), .gen_in_threshold_output_out(thr),
      .evt_gen_voltage_lacking_out(e_lack), .evt_gen_out_of_tolerance_out(e_out),
      .evt_gen_within_tolerance_out(e_in));
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {n_lack, n_out, n_in} <= '0;
      end else begin
         n_lack <= n_lack + e_lack;
         n_out  <= n_out + e_out;
         n_in   <= n_in + e_in;
      end
   end
   // =====================================================
   // reference model and helpers
   function automatic bit ok2(input logic [15:0] lo, input logic [15:0] hi);
      return lo != 0 && hi != 0 && hi > lo;
   endfunction : ok2
   function automatic bit active(input cfg_t c, input meas_t m);
      bit s, d, v, f;
      s = (c.pickup_teeth != 0 || c.rpm_per_volt != 0 || c.rpm_per_hz != 0 || c.engine_type != ENGINE_TYPE_NONE)
          && ok2(c.speed_lo, c.speed_hi) && m.speed > c.speed_lo;
      d = c.charger_dplus_input_function && ok2(c.dplus_lo, c.dplus_hi) && m.dplus > c.dplus_lo;
      v = ok2(c.volt_lo, c.volt_hi) && (m.volt_l1 > c.volt_lo || m.volt_l2 > c.volt_lo || m.volt_l3 > c.volt_lo);
      f = ok2(c.freq_lo, c.freq_hi) && m.freq > c.freq_lo;
      return s || d || v || f;
   endfunction : active
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction : rnd
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : cyc
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   task automatic restart();
      rst = 1'b1;
      cyc(6);
      rst = 1'b0;
      cyc(4);
   endtask : restart
   task automatic tally_and_finish();
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish
   // =====================================================
   // instant checks feeding the combined state
   task automatic engine_case(input int i);
      logic [15:0] mid;
      mid = 16'h0065 + rnd() % 16'h018E;
      cfg = '0;
      cmd = '0;
      cmd.oil_below_min = 1'b1;
      {cfg.speed_lo, cfg.dplus_lo, cfg.volt_lo, cfg.freq_lo} = {4{16'h0064}};
      {cfg.speed_hi, cfg.dplus_hi, cfg.volt_hi, cfg.freq_hi} = {4{16'h01F4}};
      case (i)
         0: begin cfg.pickup_teeth = 8'h10; cmd.speed = mid; end
         1: cmd.speed = mid;
         2: begin cfg.engine_type = 8'h01; cmd.speed = mid; end
         3: begin cfg.rpm_per_hz = 16'h0001; cfg.speed_hi = 16'h0064; cmd.speed = mid; end
         4: begin cfg.charger_dplus_input_function = 1'b1; cmd.dplus = mid; end
         5: cmd.dplus = mid;
         6: cmd.volt_l3 = mid;
         7: {cmd.volt_l1, cmd.volt_l2} = {2{16'h0063}};
         8: cmd.freq = 16'h0200;
         default: begin cfg.freq_lo = 16'h0300; cmd.freq = 16'h0400; end
      endcase
      restart();
      chk("engine_state", active(cfg, cmd) ? ENG_MOVING : ENG_STOPPED, eng);
   endtask : engine_case
   initial begin
      #200000;
      bad_count++;
      tally_and_finish();
   end
   initial begin
      for (int i = 0; i < 10; i++) engine_case(i);
      // starter gating: stopped passes, moving only holds
      cfg = '0;
      {cfg.speed_lo, cfg.speed_hi, cfg.pickup_teeth} = {16'h0064, 16'h01F4, 8'h10};
      cmd = '0;
      restart();
      repeat (8) begin
         req = rnd() > 16'h7FFF;
         cyc(2);
         chk("starter", req, strt);
      end
      req = 1'b1;
      cyc(2);
      cmd.speed = 16'h0100;
      cyc(4);
      chk("engine_state", ENG_MOVING, eng);
      chk("starter", 1'b1, strt);
      req = 1'b0;
      cyc(2);
      chk("starter", 1'b0, strt);
      req = 1'b1;
      cyc(3);
      chk("starter", 1'b0, strt);
      req = 1'b0;
      // generator status events, in-threshold output and transient
      for (int r = 0; r < 3; r++) begin
         cfg = '0;
         cfg.event_enable_mask = (r == 1) ? 8'h00 : 8'h04;
         gst = (r == 2) ? {GEN_LOW, GEN_HIGH} : {GEN_ABSENT, GEN_ABSENT};
         restart();
         chk("evt_lacking", r == 0, n_lack);
         chk("evt_out", r == 2, n_out);
         if (r < 2) chk("lamp", 1'b0, lamp);
         gst = {GEN_IN_TOL, GEN_IN_TOL};
         cyc(3);
         chk("gen_state", GS_TRANSIENT, gs);
         chk("in_threshold", 1'b1, thr);
         chk("evt_within", 0, n_in);
         gst.freq = GEN_LOW;
         cyc(3);
         chk("in_threshold", 1'b0, thr);
         chk("gen_state", GS_TRANSIENT, gs);
      end
      tally_and_finish();
   end
endmodule : tb_engine_run_state_qualifier
`default_nettype wire
